// ===== logic/pump_io_config_and_action_dispatch.sv
module pump_io_config_and_action_dispatch (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset
  input wire pump_ctl_pkg::axi_req_t axi_req, // axi4-lite master side
  output pump_ctl_pkg::axi_rsp_t axi_rsp, // axi4-lite slave side
  input wire logic rx_valid, // received byte strobe
  input wire logic [7:0] rx_byte, // received byte
  input wire logic [1:0] dio_in, // digital port pins
  input wire logic six_port_variant, // strap pin
  input wire pump_ctl_pkg::motor_sts_t motor_sts, // motor status
  input wire logic err_event, // error raised
  input wire logic [7:0] err_code, // raised error code
  output pump_ctl_pkg::motor_cmd_t motor_cmd, // move request
  output logic [1:0] dio_out, // port output level
  output logic [1:0] dio_oe, // port driven
  output logic [1:0] dio_source, // port stage sourcing
  output logic [2:0] valve_sel, // open valve, 0 all closed
  output logic line_ok, // addressed line accepted
  output logic line_drop, // line ignored
  output logic echo_enable, // echo received text
  output logic prompt_enable, // send prompt characters
  output logic save_req, // store settings pulse
  output logic restart_pulse // restart indication
);
  import pump_ctl_pkg::*;

  typedef struct packed {
    axi_rsp_t rsp;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    nv_t nv;
    nv_t saved;
    logic party_pend;
    logic [15:0] disp;
    logic [7:0] err_code;
    logic err_flag;
    logic stall;
    logic [2:0] valve;
    act_t act;
    logic issued;
    motor_cmd_t cmd;
    logic [5:0] refill_cnt;
    logic cfg_reject;
    logic [7:0] line_len;
    logic addr_ok;
    logic [1:0] din_s1;
    logic [1:0] din_s2;
    logic [1:0] din_s3;
    logic six_s1;
    logic six_s2;
    logic [1:0] dio_out;
    logic [1:0] dio_oe;
    logic [1:0] dio_source;
    logic line_ok;
    logic line_drop;
    logic echo_en;
    logic prompt_en;
    logic save_req;
    logic restart;
  } st_t;

  st_t st;
  st_t next_st;
  logic wr_fire;
  logic [31:0] wd;
  logic [32:0] rd;
  logic cal_go, disp_go, fill_go, quit_go, clr_go, save_go;
  logic restart_go;
  logic [17:0] fill_total;
  logic [17:0] mv_steps;
  logic mv_out;
  act_t mv_next;
  logic [1:0] flag;

  function automatic logic [32:0] rd_word(st_t s, logic [7:0] a);
    logic [31:0] d;
    logic ok;
    d = 32'h0000_0000;
    ok = 1'b1;
    unique case (a)
      OFF_CTRL: d = 32'h0000_0000;
      OFF_COMM: begin
        d[1:0] = s.nv.echo;
        d[CM_PARTY] = s.nv.party;
        d[CM_PEND] = s.party_pend;
        d[15:8] = s.nv.name;
      end
      OFF_PORT1, OFF_PORT2: begin
        d[4:0] = s.nv.port[a == OFF_PORT2].sig;
        d[PF_ACT] = s.nv.port[a == OFF_PORT2].act_high;
        d[PF_SRC] = s.nv.port[a == OFF_PORT2].source;
        d[PF_PRES+:3] = 3'h7;
      end
      OFF_DISP: d[15:0] = s.disp;
      OFF_SUCK: d[15:0] = s.nv.suck;
      OFF_FILL: d[15:0] = s.nv.ra;
      OFF_VENT: d[15:0] = s.nv.vt;
      OFF_COMP: d[15:0] = s.nv.ci;
      OFF_ERROR: d[8:0] = {s.err_flag, s.err_code};
      OFF_STALL: d[0] = s.stall;
      OFF_VALVE: d[2:0] = s.valve;
      OFF_STATUS: d[12:0] = {s.six_s2, s.refill_cnt, s.cfg_reject,
                             s.issued, s.act};
      default: ok = 1'b0;
    endcase
    return {ok, d};
  endfunction

  // all three fields present and a listed signal type
  function automatic logic cfg_ok(logic [31:0] d);
    return (d[PF_PRES+:3] == 3'h7) && (d[4:0] == SIG_RESET ||
      d[4:0] == SIG_GENERAL || d[4:0] == SIG_MOVING ||
      d[4:0] == SIG_ERROR || d[4:0] == SIG_STALL);
  endfunction

  function automatic port_cfg_t to_cfg(logic [31:0] d);
    return '{sig: d[4:0], act_high: d[PF_ACT], source: d[PF_SRC]};
  endfunction

  function automatic logic pin_active(port_cfg_t c, logic lvl);
    return c.act_high ? lvl : ~lvl;
  endfunction

  assign fill_total = 18'(st.nv.ra) + 18'(st.nv.vt) + 18'(st.nv.ci);
  assign wr_fire = st.aw_got && st.w_got && !st.rsp.bvalid;

  always_comb begin
    next_st = st;
    next_st.cmd.valid = 1'b0;
    next_st.line_ok = 1'b0;
    next_st.line_drop = 1'b0;
    next_st.save_req = 1'b0;
    next_st.restart = 1'b0;
    next_st.din_s1 = dio_in;
    next_st.din_s2 = st.din_s1;
    next_st.din_s3 = st.din_s2;
    next_st.six_s1 = six_port_variant;
    next_st.six_s2 = st.six_s1;
    {cal_go, disp_go, fill_go, quit_go, clr_go, save_go} = 6'h00;
    mv_steps = 18'h0_0000;
    mv_out = 1'b0;
    mv_next = A_IDLE;
    flag = 2'h0;
    restart_go = 1'b0;
    wd = 32'h0000_0000;
    rd = 33'h0_0000_0000;

    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end

    if (st.stall || motor_sts.stall) begin
      next_st.stall = 1'b1;
    end

    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      rd = rd_word(st, st.awaddr);
      next_st.rsp.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      for (int b = 0; b < 4; b++) begin
        wd[b*8+:8] = st.wstrb[b] ? st.wdata[b*8+:8] : rd[b*8+:8];
      end
      unique case (st.awaddr)
        OFF_CTRL: begin
          {save_go, clr_go, quit_go, fill_go, disp_go, cal_go} = wd[5:0];
        end
        OFF_COMM: begin
          next_st.nv.echo = wd[1:0];
          next_st.nv.name = wd[15:8];
          if (!wd[CM_PARTY]) begin
            next_st.nv.party = 1'b0;
            next_st.party_pend = 1'b0;
          end else if (!st.nv.party) begin
            next_st.party_pend = 1'b1;
          end
        end
        OFF_PORT1: begin
          if (cfg_ok(wd)) begin
            next_st.nv.port[0] = to_cfg(wd);
          end else begin
            next_st.cfg_reject = 1'b1;
          end
        end
        OFF_PORT2: begin
          if (cfg_ok(wd) && !st.six_s2) begin
            next_st.nv.port[1] = to_cfg(wd);
          end else begin
            next_st.cfg_reject = 1'b1;
          end
        end
        OFF_DISP: next_st.disp = wd[15:0];
        OFF_SUCK: next_st.nv.suck = wd[15:0];
        OFF_FILL: next_st.nv.ra = wd[15:0];
        OFF_VENT: next_st.nv.vt = wd[15:0];
        OFF_COMP: next_st.nv.ci = wd[15:0];
        OFF_ERROR: begin
          next_st.err_code = wd[7:0];
          next_st.err_flag = wd[7:0] != 8'h00;
        end
        OFF_STALL: next_st.stall = wd[0] || motor_sts.stall;
        OFF_VALVE: begin
          if (st.act == A_IDLE) begin
            next_st.valve = wd[2:0];
          end
        end
        default: ;
      endcase
    end

    if (axi_req.arvalid && st.rsp.arready) begin
      rd = rd_word(st, axi_req.araddr);
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rd[31:0];
      next_st.rsp.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      if (axi_req.araddr == OFF_ERROR) begin
        next_st.err_flag = 1'b0;
      end
    end

    if (clr_go) begin
      next_st.err_code = 8'h00;
      next_st.err_flag = 1'b0;
      next_st.stall = motor_sts.stall;
      next_st.cfg_reject = 1'b0;
    end
    // a new error outranks any clear in the same cycle except a restart
    if (err_event && err_code != 8'h00) begin
      next_st.err_code = err_code;
      next_st.err_flag = 1'b1;
    end

    if (save_go && st.act == A_IDLE) begin
      next_st.saved = st.nv;
      next_st.save_req = 1'b1;
    end

    unique case (st.act)
      A_IDLE: begin
        if (cal_go) begin
          next_st.act = A_CAL_HOME;
        end else if (disp_go && st.disp != 16'h0000) begin
          next_st.act = A_DISP;
        end else if (fill_go) begin
          next_st.act = A_FILL;
        end
      end
      A_CAL_HOME: begin
        mv_steps = CAL_STROKE;
        mv_out = 1'b1;
        mv_next = A_CAL_BACK;
      end
      A_CAL_BACK: begin
        mv_steps = 18'(st.nv.suck);
        mv_next = A_IDLE;
      end
      A_DISP: begin
        mv_steps = 18'(st.disp);
        mv_out = 1'b1;
        mv_next = A_SUCK;
      end
      A_SUCK: begin
        mv_steps = 18'(st.nv.suck);
        mv_next = A_IDLE;
      end
      A_FILL: begin
        mv_steps = fill_total;
        mv_next = A_VENT;
      end
      A_VENT: begin
        mv_steps = 18'(st.nv.vt);
        mv_out = 1'b1;
        mv_next = A_COMP;
      end
      A_COMP: begin
        mv_steps = 18'(st.nv.ci);
        mv_out = 1'b1;
        mv_next = A_IDLE;
      end
      A_QUIT: begin
        if (!motor_sts.moving) begin
          next_st.act = A_IDLE;
        end
      end
    endcase

    if (st.act != A_IDLE && st.act != A_QUIT) begin
      if (!st.issued && mv_steps != 18'h0_0000) begin
        next_st.cmd = '{valid: 1'b1, out_dir: mv_out, steps: mv_steps};
        next_st.issued = 1'b1;
      end else if (!st.issued || motor_sts.done) begin
        next_st.issued = 1'b0;
        next_st.act = mv_next;
        if (st.act == A_SUCK) begin
          next_st.disp = 16'h0000;
        end
        if (st.act == A_COMP) begin
          if (st.refill_cnt == REFILLS_PER_SAVE - 6'h01) begin
            next_st.refill_cnt = 6'h00;
            next_st.saved = st.nv;
            next_st.save_req = 1'b1;
          end else begin
            next_st.refill_cnt = st.refill_cnt + 6'h01;
          end
        end
      end
    end

    // quit waits for the motor instead of cutting a move short
    if (quit_go && st.act != A_IDLE) begin
      next_st.issued = 1'b0;
      next_st.act = motor_sts.moving ? A_QUIT : A_IDLE;
    end

    if (rx_valid) begin
      if (rx_byte == CH_LF || rx_byte == CH_CR) begin
        next_st.line_len = 8'h00;
        if (st.line_len == 8'h00) begin
          if (rx_byte == CH_LF && st.party_pend) begin
            next_st.nv.party = 1'b1;
            next_st.party_pend = 1'b0;
          end
        end else if (!st.nv.party || (rx_byte == CH_LF && st.addr_ok)) begin
          next_st.line_ok = 1'b1;
        end else begin
          next_st.line_drop = 1'b1;
        end
      end else begin
        if (st.line_len == 8'h00) begin
          next_st.addr_ok = rx_byte == st.nv.name || rx_byte == CH_STAR;
        end
        if (st.line_len != 8'hff) begin
          next_st.line_len = st.line_len + 8'h01;
        end
      end
    end

    for (int i = 0; i < 2; i++) begin
      unique case (st.nv.port[i].sig)
        SIG_MOVING: flag[i] = motor_sts.moving;
        SIG_ERROR: flag[i] = st.err_flag;
        SIG_STALL: flag[i] = st.stall;
        default: flag[i] = 1'b0;
      endcase
      next_st.dio_out[i] = pin_active(st.nv.port[i], flag[i]);
      next_st.dio_oe[i] = (st.nv.port[i].sig == SIG_MOVING ||
        st.nv.port[i].sig == SIG_ERROR || st.nv.port[i].sig == SIG_STALL)
        && !(i == 1 && st.six_s2);
      next_st.dio_source[i] = st.nv.port[i].source;
      if (st.nv.port[i].sig == SIG_RESET &&
          pin_active(st.nv.port[i], st.din_s2[i]) &&
          !pin_active(st.nv.port[i], st.din_s3[i])) begin
        restart_go = 1'b1;
      end
    end
    next_st.echo_en = st.nv.echo != 2'h1 && st.nv.echo != 2'h2;
    next_st.prompt_en = st.nv.echo == 2'h0;

    if (restart_go) begin
      next_st.nv = st.saved;
      next_st.act = A_CAL_HOME;
      next_st.issued = 1'b0;
      next_st.disp = 16'h0000;
      next_st.err_code = 8'h00;
      next_st.err_flag = 1'b0;
      next_st.stall = 1'b0;
      next_st.valve = 3'h0;
      next_st.party_pend = 1'b0;
      next_st.line_len = 8'h00;
      next_st.restart = 1'b1;
    end

    next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
    next_st.rsp.wready = !next_st.w_got && !next_st.rsp.bvalid;
    next_st.rsp.arready = !next_st.rsp.rvalid;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.nv <= NV_DEFAULT;
      st.saved <= NV_DEFAULT;
      st.act <= A_CAL_HOME;
    end else begin
      st <= next_st;
    end
  end

  assign axi_rsp = st.rsp;
  assign motor_cmd = st.cmd;
  assign dio_out = st.dio_out;
  assign dio_oe = st.dio_oe;
  assign dio_source = st.dio_source;
  assign valve_sel = st.valve;
  assign line_ok = st.line_ok;
  assign line_drop = st.line_drop;
  assign echo_enable = st.echo_en;
  assign prompt_enable = st.prompt_en;
  assign save_req = st.save_req;
  assign restart_pulse = st.restart;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence suck_done_s;
    st.act == A_SUCK && st.issued && motor_sts.done && !quit_go &&
      !restart_go;
  endsequence

  sequence err_read_s;
    axi_req.arvalid && st.rsp.arready && axi_req.araddr == OFF_ERROR &&
      !err_event && !restart_go && !clr_go &&
      !(wr_fire && st.awaddr == OFF_ERROR);
  endsequence

  gen_port_idle_a: assert property (
    st.nv.port[0].sig == SIG_GENERAL |=> !dio_oe[0])
    else $error("general output port is driven");
  moving_flag_a: assert property (
    st.nv.port[0].sig == SIG_MOVING && st.nv.port[0].act_high &&
    motor_sts.moving |=> dio_out[0] && dio_oe[0])
    else $error("moving flag not shown");
  err_read_a: assert property (
    err_read_s |=> !st.err_flag && st.err_code == $past(st.err_code))
    else $error("error read changed code or kept flag");
  err_set_a: assert property (
    err_event && err_code != 8'h00 && !restart_go |=>
    st.err_flag && st.err_code == $past(err_code))
    else $error("error event not latched");
  stall_hold_a: assert property (
    st.stall && !clr_go && !restart_go &&
    !(wr_fire && st.awaddr == OFF_STALL) |=> st.stall)
    else $error("stall flag dropped without clear");
  dispense_zero_a: assert property (
    suck_done_s |=> st.disp == 16'h0000 && st.act == A_IDLE)
    else $error("dispense amount not zeroed");
  refill_sum_a: assert property (
    motor_cmd.valid && st.act == A_FILL |->
    motor_cmd.steps == $past(fill_total))
    else $error("refill overfill wrong");
  party_drop_a: assert property (
    rx_valid && rx_byte == CH_CR && st.nv.party &&
    st.line_len != 8'h00 |=> line_drop && !line_ok)
    else $error("CR line accepted in party mode");
  party_on_a: assert property (
    rx_valid && rx_byte == CH_LF && st.party_pend &&
    st.line_len == 8'h00 && !restart_go |=> st.nv.party ##1 st.nv.party)
    else $error("party mode not enabled");
  cfg_reject_a: assert property (
    wr_fire && st.awaddr == OFF_PORT1 && !cfg_ok(wd) && !restart_go
    |=> st.nv.port[0] == $past(st.nv.port[0]) && st.cfg_reject)
    else $error("bad port config accepted");
  quit_wait_a: assert property (
    quit_go && st.act != A_IDLE && motor_sts.moving && !restart_go
    |=> st.act == A_QUIT)
    else $error("quit did not wait for motor");
  echo_off_a: assert property (
    st.nv.echo == 2'h1 |=> !echo_enable && !prompt_enable)
    else $error("echo still on");
endmodule

// ===== logic/pump_ctl_pkg.sv
package pump_ctl_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COMM = 8'h04;
  localparam logic [7:0] OFF_PORT1 = 8'h08;
  localparam logic [7:0] OFF_PORT2 = 8'h0c;
  localparam logic [7:0] OFF_DISP = 8'h10;
  localparam logic [7:0] OFF_SUCK = 8'h14;
  localparam logic [7:0] OFF_FILL = 8'h18;
  localparam logic [7:0] OFF_VENT = 8'h1c;
  localparam logic [7:0] OFF_COMP = 8'h20;
  localparam logic [7:0] OFF_ERROR = 8'h24;
  localparam logic [7:0] OFF_STALL = 8'h28;
  localparam logic [7:0] OFF_VALVE = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam int CTRL_CAL = 0;
  localparam int CTRL_DISP = 1;
  localparam int CTRL_FILL = 2;
  localparam int CTRL_QUIT = 3;
  localparam int CTRL_CLEAR = 4;
  localparam int CTRL_SAVE = 5;
  localparam int PF_ACT = 8;
  localparam int PF_SRC = 12;
  localparam int PF_PRES = 16;
  localparam int CM_PARTY = 2;
  localparam int CM_PEND = 3;
  localparam logic [4:0] SIG_RESET = 5'h0b;
  localparam logic [4:0] SIG_GENERAL = 5'h10;
  localparam logic [4:0] SIG_MOVING = 5'h11;
  localparam logic [4:0] SIG_ERROR = 5'h12;
  localparam logic [4:0] SIG_STALL = 5'h13;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] NAME_DEFAULT = 8'h21;
  localparam logic [15:0] SUCK_DEFAULT = 16'h032d;
  localparam logic [5:0] REFILLS_PER_SAVE = 6'h32;
  localparam logic [17:0] CAL_STROKE = 18'h0_bb80;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic valid;
    logic out_dir;
    logic [17:0] steps;
  } motor_cmd_t;

  typedef struct packed {
    logic done;
    logic moving;
    logic stall;
  } motor_sts_t;

  typedef struct packed {
    logic [4:0] sig;
    logic act_high;
    logic source;
  } port_cfg_t;

  typedef struct packed {
    port_cfg_t [1:0] port;
    logic [1:0] echo;
    logic [7:0] name;
    logic party;
    logic [15:0] suck;
    logic [15:0] ra;
    logic [15:0] vt;
    logic [15:0] ci;
  } nv_t;

  localparam port_cfg_t PORT_DEFAULT = '{sig: SIG_GENERAL, act_high: 1'b0,
                                         source: 1'b0};
  localparam nv_t NV_DEFAULT = '{port: {PORT_DEFAULT, PORT_DEFAULT},
    echo: 2'h0, name: NAME_DEFAULT, party: 1'b0, suck: SUCK_DEFAULT,
    ra: 16'h0000, vt: 16'h0000, ci: 16'h0000};

  typedef enum logic [3:0] {
    A_IDLE, A_CAL_HOME, A_CAL_BACK, A_DISP, A_SUCK,
    A_FILL, A_VENT, A_COMP, A_QUIT
  } act_t;
endpackage

// ===== verif/motor_model.sv
module motor_model (
  input wire logic core_clk, // system clock
  input wire logic reset_n, // async reset
  input wire pump_ctl_pkg::motor_cmd_t motor_cmd, // move request
  input wire logic [7:0] move_time, // cycles per move, at least 2
  input wire logic stall_in, // forced stall level
  output pump_ctl_pkg::motor_sts_t motor_sts // motor status
);
  timeunit 1ns;
  timeprecision 1ps;
  import pump_ctl_pkg::*;
  logic [7:0] cnt;
  // move time ignores step count so long strokes stay short
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 8'h00;
      motor_sts <= '0;
    end else begin
      motor_sts.stall <= stall_in;
      // done pulses in the same cycle that moving drops, one assignment per edge
      motor_sts.done <= !motor_cmd.valid && cnt <= 8'h01 &&
                        motor_sts.moving;
      if (motor_cmd.valid) begin
        cnt <= move_time;
        motor_sts.moving <= 1'b1;
      end else if (cnt > 8'h01) begin
        cnt <= cnt - 8'h01;
      end else if (motor_sts.moving) begin
        motor_sts.moving <= 1'b0;
      end
    end
  end
endmodule

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pump_ctl_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  axi_req_t axi_req = '0;
  axi_rsp_t axi_rsp;
  logic rx_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [1:0] dio_in = 2'h0;
  logic six_port_variant = 1'b0;
  motor_sts_t motor_sts;
  logic err_event = 1'b0;
  logic [7:0] err_code = 8'h00;
  motor_cmd_t motor_cmd;
  logic [1:0] dio_out, dio_oe, dio_source;
  logic [2:0] valve_sel;
  logic line_ok, line_drop, echo_enable, prompt_enable, save_req;
  logic restart_pulse;
  logic [7:0] move_time = 8'h14;
  logic stall_in = 1'b0;
  logic [18:0] q[$];
  logic [1:0] seen = 2'h0;
  logic rst_seen = 1'b0;
  int n_save = 0;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] d;

  pump_io_config_and_action_dispatch i_pump_io_config_and_action_dispatch (
    .core_clk, .reset_n, .axi_req, .axi_rsp, .rx_valid, .rx_byte, .dio_in,
    .six_port_variant, .motor_sts, .err_event, .err_code, .motor_cmd,
    .dio_out, .dio_oe, .dio_source, .valve_sel, .line_ok, .line_drop,
    .echo_enable, .prompt_enable, .save_req, .restart_pulse);
  motor_model i_motor_model (.core_clk, .reset_n, .motor_cmd, .move_time,
    .stall_in, .motor_sts);

  always #4 core_clk = ~core_clk;
  // pulses are latched here so no check depends on exact latency
  always @(posedge core_clk) begin
    if (motor_cmd.valid === 1'b1) begin
      q.push_back({motor_cmd.out_dir, motor_cmd.steps});
    end
    if (save_req === 1'b1) n_save++;
    if (line_ok === 1'b1) seen[0] = 1'b1;
    if (line_drop === 1'b1) seen[1] = 1'b1;
    if (restart_pulse === 1'b1) rst_seen = 1'b1;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge core_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= v;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    while (pa || pw) begin
      @(posedge core_clk);
      if (pa && axi_rsp.awready === 1'b1) begin
        pa = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (pw && axi_rsp.wready === 1'b1) begin
        pw = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do @(posedge core_clk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge core_clk); while (axi_rsp.rvalid !== 1'b1);
    v = axi_rsp.rdata;
    axi_req.rready <= 1'b0;
  endtask
  task automatic mv(input logic [18:0] e);
    while (q.size() == 0) @(posedge core_clk);
    chk("motor move", 32'(e), 32'(q.pop_front()));
  endtask
  task automatic idle;
    do rd(OFF_STATUS, d); while (d[3:0] !== 4'h0);
  endtask
  task automatic line(input string s);
    seen = 2'h0;
    foreach (s[i]) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte <= s[i];
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    tick(3);
  endtask
  task automatic err;
    err_event <= 1'b1;
    err_code <= 8'h05;
    @(posedge core_clk);
    err_event <= 1'b0;
    tick(4);
  endtask
  task automatic results;
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    results;
  end

  initial begin
    tick(20);
    reset_n <= 1'b1;
    mv({1'b1, CAL_STROKE});
    mv({1'b0, 18'h0_032d});
    idle;
    rd(OFF_COMM, d);
    chk("name", 32'h0000_0021, 32'(d[15:8]));
    rd(OFF_PORT1, d);
    chk("port1", 32'h0007_0010, d);
    chk("oe", 32'h0000_0000, 32'(dio_oe));
    wr(OFF_PORT1, 32'h0007_1111);
    wr(OFF_PORT1, 32'h0003_0013);
    rd(OFF_PORT1, d);
    chk("port1", 32'h0007_1111, d);
    wr(OFF_DISP, 32'h0000_0064);
    wr(OFF_CTRL, 32'h0000_0002);
    mv({1'b1, 18'h0_0064});
    tick(4);
    chk("moving", 32'h0000_0007,
        32'({dio_out[0], dio_oe[0], dio_source[0]}));
    mv({1'b0, 18'h0_032d});
    idle;
    chk("moving", 32'h0000_0000, 32'(dio_out[0]));
    rd(OFF_DISP, d);
    chk("amount", 32'h0000_0000, d);
    wr(OFF_CTRL, 32'h0000_0002);
    tick(10);
    chk("moves", 32'h0000_0000, 32'(q.size()));
    wr(OFF_PORT2, 32'h0007_0012);
    tick(4);
    chk("errport", 32'h0000_0006,
        32'({dio_out[1], dio_oe[1], dio_source[1]}));
    err;
    chk("errport", 32'h0000_0000, 32'(dio_out[1]));
    rd(OFF_ERROR, d);
    chk("code", 32'h0000_0005, 32'(d[7:0]));
    tick(4);
    chk("errport", 32'h0000_0001, 32'(dio_out[1]));
    rd(OFF_ERROR, d);
    chk("code", 32'h0000_0005, 32'(d[7:0]));
    err;
    wr(OFF_CTRL, 32'h0000_0010);
    tick(4);
    chk("errport", 32'h0000_0001, 32'(dio_out[1]));
    wr(OFF_PORT2, 32'h0007_1113);
    stall_in <= 1'b1;
    tick(3);
    stall_in <= 1'b0;
    tick(4);
    chk("stall", 32'h0000_0003, 32'({dio_out[1], dio_source[1]}));
    wr(OFF_STALL, 32'h0000_0000);
    tick(4);
    chk("stall", 32'h0000_0000, 32'(dio_out[1]));
    six_port_variant <= 1'b1;
    tick(4);
    chk("oe2", 32'h0000_0000, 32'(dio_oe[1]));
    wr(OFF_PORT2, 32'h0007_0010);
    rd(OFF_PORT2, d);
    chk("port2", 32'h0007_1113, d);
    six_port_variant <= 1'b0;
    wr(OFF_VALVE, 32'h0000_0003);
    tick(2);
    chk("valve", 32'h0000_0003, 32'(valve_sel));
    wr(OFF_VALVE, 32'h0000_0000);
    tick(2);
    chk("valve", 32'h0000_0000, 32'(valve_sel));
    wr(OFF_COMM, 32'h0000_2101);
    tick(2);
    chk("echo", 32'h0000_0000, 32'({echo_enable, prompt_enable}));
    wr(OFF_COMM, 32'h0000_2105);
    line("\n");
    rd(OFF_COMM, d);
    chk("party", 32'h0000_0001, 32'(d[2]));
    line("PX\n");
    chk("line", 32'h0000_0002, 32'(seen));
    line("!X\n");
    chk("line", 32'h0000_0001, 32'(seen));
    line("*X\n");
    chk("line", 32'h0000_0001, 32'(seen));
    line("!X\r");
    chk("line", 32'h0000_0002, 32'(seen));
    wr(OFF_FILL, 32'h0000_000a);
    wr(OFF_VENT, 32'h0000_0003);
    wr(OFF_COMP, 32'h0000_0002);
    n_save = 0;
    wr(OFF_CTRL, 32'h0000_0020);
    tick(3);
    chk("saves", 32'h0000_0001, 32'(n_save));
    n_save = 0;
    move_time <= 8'h08;
    for (int i = 0; i < 50; i++) begin
      wr(OFF_CTRL, 32'h0000_0004);
      if (i == 0) begin
        mv({1'b0, 18'h0_000f});
        mv({1'b1, 18'h0_0003});
        mv({1'b1, 18'h0_0002});
      end
      idle;
    end
    chk("saves", 32'h0000_0001, 32'(n_save));
    q.delete();
    move_time <= 8'h40;
    wr(OFF_CTRL, 32'h0000_0004);
    while (q.size() == 0) @(posedge core_clk);
    wr(OFF_CTRL, 32'h0000_0008);
    rd(OFF_STATUS, d);
    chk("quit", 32'h0000_0008, 32'(d[3:0]));
    idle;
    chk("moves", 32'h0000_0001, 32'(q.size()));
    q.delete();
    wr(OFF_PORT1, 32'h0007_010b);
    dio_in <= 2'h1;
    mv({1'b1, CAL_STROKE});
    chk("restart", 32'h0000_0001, 32'(rst_seen));
    rd(OFF_PORT1, d);
    chk("port1", 32'h0007_1111, d);
    mv({1'b0, 18'h0_032d});
    idle;
    wr(OFF_CTRL, 32'h0000_0001);
    mv({1'b1, CAL_STROKE});
    mv({1'b0, 18'h0_032d});
    results;
  end
endmodule
